// >>> logic/arc_params.svh
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

`define ARC_CHR_ACK 8'h2a
`define ARC_CHR_ERR 8'h3f
`define ARC_CHR_CR 8'h0d
`define ARC_CHR_LF 8'h0a
`define ARC_CHR_SHORT 8'h24
`define ARC_CHR_LONG 8'h23
`define ARC_CHR_SPACE 8'h20
`define ARC_CHR_MIN_KEEP 8'h23
`define ARC_CHR_PAR_MASK 8'h7f
`define ARC_HEX_DIGIT 8'h30
`define ARC_HEX_LETTER 8'h37
`define ARC_MAX_CMD 5'h19
`define ARC_MAX_BODY 5'h17
`define ARC_MAX_RSP 5'h19
`define ARC_ERR_LEN 5'h0c
`define ARC_ERR_TXT_BADCK "BAD CHECKSUM"
`define ARC_ERR_TXT_SYNTAX "SYNTAX ERROR"

`endif

// >>> logic/arc_pkg.sv
package arc_pkg;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } arc_beat_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic none;
        logic [7:0] data;
    } arc_rsp_t;

    typedef enum logic [1:0] {KIND_OK, KIND_BADCK, KIND_SYNTAX} arc_kind_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_ADDR, RX_BODY, RX_SKIP, RX_JUDGE, RX_WAIT
    } arc_rx_st_t;

    typedef enum logic [3:0] {
        TX_IDLE, TX_PROMPT, TX_ADDR, TX_ECHO, TX_DATA, TX_CKHI, TX_CKLO,
        TX_CR, TX_LF, TX_ESP, TX_ETXT
    } arc_tx_st_t;

endpackage : arc_pkg

// >>> logic/arc_core.sv
// Notes on behaviour
// - Accepted command answers start with asterisk.
// - Error answers start with question mark.
// - Every answer ends with carriage return, then linefeed when lf_en_i is set.
// - Answers never exceed 25 characters, not counting the linefeed.
// - Short-form no-data commands answer asterisk plus CR.
// - Accepted long form echoes address, command, adds checksum.
// - Long prompt accepted for every command.
// - Two surplus characters are an optional checksum.
// - Checksum mismatch aborts with bad-checksum error.
// - Checksum match executes the command.
// - One surplus character gives syntax error.
// - Checksum is low byte, two hex characters.
// - Checksum sits right before final CR.
// - Linefeeds never enter the checksum.
// - Parity bits never enter the checksum.
// - Carriage return ends every command.
// - After address drop codes below 23h.
// - Over 25 command characters: abort silently.
`timescale 1ns/10ps
`include "arc_params.svh"

module arc_core (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic lf_en_i,
    input wire arc_pkg::arc_beat_t rx_i,
    input wire logic [4:0] cmd_len_i,
    output logic cmd_go_o,
    output logic cmd_long_o,
    output logic [15:0] cmd_op_o,
    input wire arc_pkg::arc_rsp_t rsp_i,
    output logic rsp_ready_o,
    output arc_pkg::arc_beat_t tx_o,
    input wire logic tx_ready_i
);
    import arc_pkg::*;

    function automatic logic [7:0] hexc(input logic [3:0] nib);
        hexc = (nib < 4'ha) ? `ARC_HEX_DIGIT + {4'h0, nib} : `ARC_HEX_LETTER + {4'h0, nib};
    endfunction : hexc

    function automatic logic [7:0] err_char(input arc_kind_t k, input logic [4:0] idx);
        logic [95:0] txt;
        txt = (k == KIND_BADCK) ? `ARC_ERR_TXT_BADCK : `ARC_ERR_TXT_SYNTAX;
        err_char = txt[8*(11-idx) +: 8];
    endfunction : err_char

    // Receive side state.
    arc_rx_st_t rx_st_q, rx_st_d;
    logic [4:0] n_q, n_d;
    logic [4:0] len_q, len_d;
    logic [7:0] sum_q, sum_d;
    logic long_q, long_d;
    logic go_q, go_d;
    logic start_q, start_d;
    arc_kind_t kind_q, kind_d;
    logic [7:0] buf_q [0:22];
    logic [7:0] buf_d [0:22];

    // Transmit side state.
    arc_tx_st_t tx_st_q, tx_st_d;
    logic [4:0] idx_q, idx_d;
    logic [4:0] cnt_q, cnt_d;
    logic [7:0] csum_q, csum_d;
    arc_beat_t tx_q, tx_d;
    logic ready_q, ready_d;

    logic [7:0] c;
    logic [7:0] rsum;
    logic ck_match;
    logic tx_done;

    // The parity bit is stripped before anything looks at the character.
    assign c = rx_i.data & `ARC_CHR_PAR_MASK;
    assign rsum = sum_q - buf_q[5'(n_q - 5'h2)] - buf_q[5'(n_q - 5'h1)];
    assign ck_match = (buf_q[5'(n_q - 5'h2)] == hexc(rsum[7:4])) &&
                      (buf_q[5'(n_q - 5'h1)] == hexc(rsum[3:0]));
    assign tx_done = (tx_st_q == TX_IDLE) && !tx_q.valid && !start_q;

    always_comb begin
        rx_st_d = rx_st_q;
        n_d = n_q;
        len_d = len_q;
        sum_d = sum_q;
        long_d = long_q;
        go_d = 1'b0;
        start_d = 1'b0;
        kind_d = kind_q;
        buf_d = buf_q;
        case (rx_st_q)
            RX_IDLE: begin
                if (rx_i.valid && (c == `ARC_CHR_SHORT || c == `ARC_CHR_LONG)) begin
                    long_d = (c == `ARC_CHR_LONG);
                    sum_d = c;
                    n_d = 5'h0;
                    rx_st_d = RX_ADDR;
                end
            end
            RX_ADDR: begin
                if (rx_i.valid) begin
                    if (c == addr_i) begin
                        sum_d = sum_q + c;
                        rx_st_d = RX_BODY;
                    end else begin
                        rx_st_d = (c == `ARC_CHR_CR) ? RX_IDLE : RX_SKIP;
                    end
                end
            end
            RX_BODY: begin
                if (rx_i.valid) begin
                    if (c == `ARC_CHR_CR) begin
                        rx_st_d = RX_JUDGE;
                    end else if (c == `ARC_CHR_SHORT || c == `ARC_CHR_LONG) begin
                        // A second prompt drops the old command and opens a new one.
                        long_d = (c == `ARC_CHR_LONG);
                        sum_d = c;
                        n_d = 5'h0;
                        rx_st_d = RX_ADDR;
                    end else if (c < `ARC_CHR_MIN_KEEP) begin
                        rx_st_d = RX_BODY;
                    end else if (n_q == `ARC_MAX_BODY) begin
                        rx_st_d = RX_SKIP;
                    end else begin
                        buf_d[n_q] = c;
                        n_d = n_q + 5'h1;
                        sum_d = sum_q + c;
                    end
                end
            end
            RX_SKIP: begin
                if (rx_i.valid && c == `ARC_CHR_CR) begin
                    rx_st_d = RX_IDLE;
                end
            end
            RX_JUDGE: begin
                len_d = cmd_len_i;
                start_d = 1'b1;
                rx_st_d = RX_WAIT;
                if (n_q == cmd_len_i) begin
                    kind_d = KIND_OK;
                    go_d = 1'b1;
                end else if (n_q == 5'(cmd_len_i + 5'h2)) begin
                    kind_d = ck_match ? KIND_OK : KIND_BADCK;
                    go_d = ck_match;
                end else begin
                    kind_d = KIND_SYNTAX;
                end
            end
            RX_WAIT: begin
                // Characters arriving while the answer is out are dropped.
                if (tx_done) begin
                    rx_st_d = RX_IDLE;
                end
            end
            default: rx_st_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_st_q <= RX_IDLE;
            n_q <= 5'h0;
            len_q <= 5'h0;
            sum_q <= 8'h00;
            long_q <= 1'b0;
            go_q <= 1'b0;
            start_q <= 1'b0;
            kind_q <= KIND_OK;
            for (int i = 0; i < 23; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else begin
            rx_st_q <= rx_st_d;
            n_q <= n_d;
            len_q <= len_d;
            sum_q <= sum_d;
            long_q <= long_d;
            go_q <= go_d;
            start_q <= start_d;
            kind_q <= kind_d;
            buf_q <= buf_d;
        end
    end

    logic load;
    logic add_sum;
    logic [7:0] ch;
    logic [4:0] reserve;

    always_comb begin
        tx_st_d = tx_st_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        csum_d = csum_q;
        load = 1'b0;
        add_sum = 1'b0;
        ch = 8'h00;
        // Room for checksum and CR is kept back so the data never pushes past the cap.
        reserve = long_q ? 5'h3 : 5'h1;
        tx_d = tx_q;
        if (tx_q.valid && tx_ready_i) begin
            tx_d.valid = 1'b0;
        end
        if (!tx_q.valid) begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (start_q) begin
                        tx_st_d = TX_PROMPT;
                        cnt_d = 5'h0;
                        csum_d = 8'h00;
                        idx_d = 5'h0;
                    end
                end
                TX_PROMPT: begin
                    load = 1'b1;
                    add_sum = 1'b1;
                    ch = (kind_q == KIND_OK) ? `ARC_CHR_ACK : `ARC_CHR_ERR;
                    tx_st_d = (kind_q != KIND_OK || long_q) ? TX_ADDR : TX_DATA;
                end
                TX_ADDR: begin
                    load = 1'b1;
                    add_sum = 1'b1;
                    ch = addr_i;
                    tx_st_d = (kind_q == KIND_OK) ? TX_ECHO : TX_ESP;
                end
                TX_ECHO: begin
                    if (idx_q == len_q || 5'(cnt_q + reserve) >= `ARC_MAX_RSP) begin
                        tx_st_d = TX_DATA;
                    end else begin
                        load = 1'b1;
                        add_sum = 1'b1;
                        ch = buf_q[idx_q];
                        idx_d = idx_q + 5'h1;
                    end
                end
                TX_DATA: begin
                    if (ready_q && rsp_i.valid) begin
                        load = !rsp_i.none;
                        add_sum = 1'b1;
                        ch = rsp_i.data & `ARC_CHR_PAR_MASK;
                        if (rsp_i.last) begin
                            tx_st_d = long_q ? TX_CKHI : TX_CR;
                        end
                    end else if (5'(cnt_q + reserve) >= `ARC_MAX_RSP) begin
                        tx_st_d = long_q ? TX_CKHI : TX_CR;
                    end
                end
                TX_CKHI: begin
                    load = 1'b1;
                    ch = hexc(csum_q[7:4]);
                    tx_st_d = TX_CKLO;
                end
                TX_CKLO: begin
                    load = 1'b1;
                    ch = hexc(csum_q[3:0]);
                    tx_st_d = TX_CR;
                end
                TX_CR: begin
                    load = 1'b1;
                    ch = `ARC_CHR_CR;
                    tx_st_d = lf_en_i ? TX_LF : TX_IDLE;
                end
                TX_LF: begin
                    tx_d.valid = 1'b1;
                    tx_d.data = `ARC_CHR_LF;
                    tx_st_d = TX_IDLE;
                end
                TX_ESP: begin
                    load = 1'b1;
                    ch = `ARC_CHR_SPACE;
                    idx_d = 5'h0;
                    tx_st_d = TX_ETXT;
                end
                TX_ETXT: begin
                    load = 1'b1;
                    ch = err_char(kind_q, idx_q);
                    idx_d = idx_q + 5'h1;
                    if (idx_q == `ARC_ERR_LEN - 5'h1) begin
                        tx_st_d = TX_CR;
                    end
                end
                default: tx_st_d = TX_IDLE;
            endcase
        end
        if (load) begin
            tx_d.valid = 1'b1;
            tx_d.data = ch;
            cnt_d = cnt_q + 5'h1;
        end
        if (load && add_sum) begin
            csum_d = csum_q + ch;
        end
        ready_d = (tx_st_d == TX_DATA) && !tx_d.valid && !(ready_q && rsp_i.valid) &&
                  (5'(cnt_d + reserve) < `ARC_MAX_RSP);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_st_q <= TX_IDLE;
            idx_q <= 5'h0;
            cnt_q <= 5'h0;
            csum_q <= 8'h00;
            tx_q <= '0;
            ready_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            csum_q <= csum_d;
            tx_q <= tx_d;
            ready_q <= ready_d;
        end
    end

    assign cmd_go_o = go_q;
    assign cmd_long_o = long_q;
    assign cmd_op_o = {buf_q[0], buf_q[1]};
    assign rsp_ready_o = ready_q;
    assign tx_o = tx_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_ack_prompt: assert property (tx_st_q == TX_PROMPT && !tx_q.valid && kind_q == KIND_OK
        |=> tx_q.valid && tx_q.data == `ARC_CHR_ACK) else $error("ack prompt wrong");
    a_err_prompt: assert property (tx_st_q == TX_PROMPT && !tx_q.valid && kind_q != KIND_OK
        |=> tx_q.valid && tx_q.data == `ARC_CHR_ERR) else $error("error prompt wrong");
    a_end_cr: assert property (tx_st_q == TX_CR && !tx_q.valid
        |=> tx_q.valid && tx_q.data == `ARC_CHR_CR) else $error("no closing CR");
    a_rsp_len_cap: assert property (cnt_q <= `ARC_MAX_RSP)
        else $error("answer too long");
    a_bad_cksum: assert property (rx_st_q == RX_JUDGE && n_q == 5'(cmd_len_i + 5'h2) && !ck_match
        |=> kind_q == KIND_BADCK && !cmd_go_o) else $error("bad checksum not flagged");
    a_good_cksum: assert property (rx_st_q == RX_JUDGE && n_q == 5'(cmd_len_i + 5'h2) && ck_match
        |=> cmd_go_o && kind_q == KIND_OK) else $error("good checksum not run");
    a_syntax_err: assert property (rx_st_q == RX_JUDGE && n_q == 5'(cmd_len_i + 5'h1)
        |=> kind_q == KIND_SYNTAX && !cmd_go_o) else $error("syntax error missed");
    a_plain_exec: assert property (rx_st_q == RX_JUDGE && n_q == cmd_len_i
        |=> cmd_go_o ##1 !cmd_go_o) else $error("plain command not run");
    a_long_abort: assert property (rx_st_q == RX_BODY && rx_i.valid && n_q == `ARC_MAX_BODY &&
        c > `ARC_CHR_SHORT |=> rx_st_q == RX_SKIP) else $error("overlong not dropped");

endmodule : arc_core

// >>> tb/arc_host_model.sv
`timescale 1ns/10ps
`include "arc_params.svh"

module arc_host_model (
    input wire logic clk_i,
    input wire arc_pkg::arc_beat_t tx_i,
    output logic tx_ready_o,
    output arc_pkg::arc_beat_t rx_o
);
    import arc_pkg::*;

    logic [7:0] got_q[$];

    initial begin
        tx_ready_o = 1'b0;
        rx_o = '0;
    end

    // The terminal stalls at random, so every answer character must wait for it.
    always @(posedge clk_i) begin
        if (tx_i.valid === 1'b1 && tx_ready_o === 1'b1) begin
            got_q.push_back(tx_i.data);
        end
        tx_ready_o <= ($urandom % 3) != 0;
    end

    // After the closing CR valid drops and the data lines carry its inverse, so a stale value never reads as new.
    task automatic send(input string s, input bit par);
        logic [7:0] c;
        for (int i = 0; i < s.len(); i++) begin
            c = s[i];
            if (par) begin
                c[7] = $urandom % 2;
            end
            @(posedge clk_i);
            rx_o <= {1'b1, c};
        end
        @(posedge clk_i);
        rx_o <= {1'b1, `ARC_CHR_CR};
        @(posedge clk_i);
        rx_o <= {1'b0, ~`ARC_CHR_CR};
    endtask : send
endmodule : arc_host_model

// >>> tb/tb.sv
`timescale 1ns/10ps
`include "arc_params.svh"

module tb;
    import arc_pkg::*;

    logic clk_i;
    logic srst_i;
    logic lf_en_i;
    logic [4:0] cmd_len_i;
    arc_beat_t rx;
    arc_beat_t tx;
    logic tx_ready;
    arc_rsp_t rsp;
    logic cmd_go_o;
    logic cmd_long_o;
    logic rsp_ready_o;
    logic [15:0] cmd_op_o;
    int fails;
    int total_checks;
    int gos;
    int cycles;
    logic [7:0] data_q[$];
    string d;
    int dl;

    arc_core dut_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(8'h31), .lf_en_i(lf_en_i),
        .rx_i(rx), .cmd_len_i(cmd_len_i), .cmd_go_o(cmd_go_o), .cmd_long_o(cmd_long_o),
        .cmd_op_o(cmd_op_o), .rsp_i(rsp), .rsp_ready_o(rsp_ready_o), .tx_o(tx),
        .tx_ready_i(tx_ready));

    arc_host_model host_u (.clk_i(clk_i), .tx_i(tx), .tx_ready_o(tx_ready), .rx_o(rx));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk_i) begin
        cycles++;
        if (cmd_go_o === 1'b1) begin
            gos++;
        end
        if (cycles >= 60000) begin
            fails++;
            $display("[FAIL] %0t: run did not finish in time", $time);
            complete_run();
        end
    end

    // Executor: one beat per take; the tail is dropped once the answer's CR is loaded.
    initial begin
        rsp = '0;
        forever begin
            @(posedge clk_i);
            if (cmd_go_o === 1'b1) begin
                automatic int n = data_q.size();
                automatic bit stop = 1'b0;
                for (int i = 0; i < n || (i == 0 && n == 0); i++) begin
                    rsp <= {1'b1, i >= n - 1, n == 0, (n == 0) ? 8'h00 : data_q[i]};
                    do begin
                        @(posedge clk_i);
                        stop = tx.valid === 1'b1 && tx.data === `ARC_CHR_CR;
                    end while (rsp_ready_o !== 1'b1 && !stop);
                    if (stop) begin
                        break;
                    end
                end
                rsp <= '0;
            end
        end
    end

    function automatic byte dig(input logic [3:0] v);
        return (v < 4'ha) ? 8'h30 + v : 8'h37 + v;
    endfunction : dig

    function automatic string hex2(input string s);
        logic [7:0] sum;
        string r;
        sum = 8'h00;
        for (int i = 0; i < s.len(); i++) begin
            sum = sum + s[i];
        end
        r = "00";
        r[0] = dig(sum[7:4]);
        r[1] = dig(sum[3:0]);
        return r;
    endfunction : hex2

    // Bit 16 is the long form; the low half holds the first two command characters.
    function automatic logic [16:0] op_of(input string s);
        logic [16:0] r;
        int j;
        r = 17'h00000;
        j = 0;
        for (int i = 0; i < s.len(); i++) begin
            if (s[i] == "$" || s[i] == "#") begin
                r[16] = (s[i] == "#");
                j = -1;
            end else if (j < 0) begin
                j = 0;
            end else if (s[i] >= 8'h23 && j < 2) begin
                r[15 - 8 * j -: 8] = s[i];
                j++;
            end
        end
        return r;
    endfunction : op_of

    // An empty expectation means silence; exact=0 only bounds the length and the frame.
    task automatic run(input string cmd, input logic [4:0] len, input bit par, input string dat,
        input string exp, input int go_exp, input bit exact);
        int k;
        int n;
        int lf;
        bit bad;
        @(posedge clk_i);
        cmd_len_i <= len;
        data_q = {};
        for (int i = 0; i < dat.len(); i++) begin
            data_q.push_back(dat[i]);
        end
        host_u.got_q = {};
        gos = 0;
        lf = (lf_en_i === 1'b1) ? 1 : 0;
        host_u.send(cmd, par);
        k = 0;
        while (k < 3000 && !(host_u.got_q.size() > 0 &&
            host_u.got_q[$] === (lf ? `ARC_CHR_LF : `ARC_CHR_CR))) begin
            @(posedge clk_i);
            k++;
        end
        repeat (20) @(posedge clk_i);
        n = (exact) ? exp.len() : host_u.got_q.size() - 1 - lf;
        bad = 1'b0;
        if (exp.len() == 0) begin
            bad = host_u.got_q.size() != 0;
        end else if (n < 1 || host_u.got_q.size() != n + 1 + lf || n > 24) begin
            bad = 1'b1;
        end else begin
            for (int i = 0; i < n; i++) begin
                if (exact && host_u.got_q[i] !== exp[i]) bad = 1'b1;
            end
            if (host_u.got_q[0] !== exp[0]) bad = 1'b1;
            if (host_u.got_q[n] !== `ARC_CHR_CR) bad = 1'b1;
            if (lf && host_u.got_q[n + 1] !== `ARC_CHR_LF) bad = 1'b1;
        end
        total_checks++;
        if (bad) begin
            fails++;
            $display("[FAIL] %0t: answer to %s differs", $time, cmd);
        end
        if (exp.len() != 0) begin
            total_checks++;
            if ({cmd_long_o, cmd_op_o} !== op_of(cmd)) begin
                fails++;
                $display("[FAIL] %0t: opcode or form wrong for %s", $time, cmd);
            end
        end
        total_checks++;
        if (gos != go_exp) begin
            fails++;
            $display("[FAIL] %0t: go count %0d for %s", $time, gos, cmd);
        end
    endtask : run

    initial begin
        void'($urandom(74));
        srst_i = 1'b1;
        lf_en_i = 1'b0;
        cmd_len_i = 5'h00;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        run("$1WE", 5'h02, 0, "", "*", 1, 1);
        run({"#1WE", hex2("#1WE")}, 5'h02, 0, "", {"*1WE", hex2("*1WE")}, 1, 1);
        run("$1WEF", 5'h02, 0, "", "?1 SYNTAX ERROR", 0, 1);
        run("$1WE00", 5'h02, 0, "", "?1 BAD CHECKSUM", 0, 1);
        run("$1W$1WE", 5'h02, 0, "", "*", 1, 1);
        run("$1RDXXXXXXXXXXXXXXXXXXXXXX", 5'h02, 0, "", "", 0, 1);
        run("$2WE", 5'h02, 0, "", "", 0, 1);
        run("$1RD", 5'h02, 0, "012345678901234567890123456789",
            "*01234567890123456789012", 1, 1);
        @(posedge clk_i);
        lf_en_i <= 1'b1;
        run("#1 RD", 5'h02, 1, "+99999.99", {"*1RD+99999.99", hex2("*1RD+99999.99")}, 1, 1);
        @(posedge clk_i);
        lf_en_i <= 1'b0;
        for (int t = 0; t < 6; t++) begin
            d = "";
            dl = (t == 0) ? 23 : 1 + $urandom % 23;
            for (int j = 0; j < dl; j++) begin
                d = {d, "0"};
                d[j] = 8'h30 + $urandom % 10;
            end
            run("$1RD", 5'h02, 1, d, {"*", d}, 1, 1);
        end
        complete_run();
    end
endmodule : tb
